// >>> common/cprb_defines.svh
// register offsets, field positions, reset values and serial port counts
// assumes a 13-bit register address and byte-wide registers
`ifndef CPRB_DEFINES_SVH
`define CPRB_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CPRB_OFS_PORT_CFG 13'h0000
`define CPRB_OFS_SI_REV 13'h0002
`define CPRB_OFS_PART_IDENTIFIER 13'h0003
`define CPRB_OFS_RB_SEL 13'h0004
`define CPRB_OFS_EE_VER_LO 13'h0005
`define CPRB_OFS_EE_VER_HI 13'h0006
`define CPRB_OFS_PUMP 13'h0010
`define CPRB_OFS_REF_LO 13'h0011
`define CPRB_OFS_REF_HI 13'h0012
`define CPRB_OFS_SWALLOW 13'h0013
`define CPRB_OFS_FB_LO 13'h0014
`define CPRB_OFS_FB_HI 13'h0015
`define CPRB_OFS_LOOP1 13'h0016

// ------------------------------------------------------------
// field positions and masks
// ------------------------------------------------------------
`define CPRB_CFG_SDO_HI 7
`define CPRB_CFG_LSB_HI 6
`define CPRB_CFG_SRST_HI 5
`define CPRB_CFG_SRST_LO 2
`define CPRB_CFG_LSB_LO 1
`define CPRB_CFG_SDO_LO 0
`define CPRB_CFG_KEEP_MASK 8'hC3
`define CPRB_RB_SEL_MASK 8'h01
`define CPRB_REF_HI_W 6
`define CPRB_SWALLOW_W 6
`define CPRB_FB_HI_W 5

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CPRB_RST_PORT_CFG 8'h00
`define CPRB_RST_RB_SEL 8'h00
`define CPRB_RST_EE_VER 8'h00
`define CPRB_RST_PUMP 8'h7D
`define CPRB_RST_REF_DIV 14'h0001
`define CPRB_RST_SWALLOW 6'h00
`define CPRB_RST_FB_DIV 13'h0000
`define CPRB_RST_LOOP1 8'h06
// identity values, arbitrary
`define CPRB_SI_REV_VAL 8'h5A
`define CPRB_PART_IDENTIFIER_VAL 8'hA5

// ------------------------------------------------------------
// serial port counts
// ------------------------------------------------------------
`define CPRB_INSTR_LAST 4'hF
`define CPRB_BYTE_LAST 4'h7
`define CPRB_RD_BIT 14

`endif

// >>> common/cprb_pkg.sv
// types shared by the register bank and its serial port
// assumes cprb_defines.svh for all numeric values
package cprb_pkg;
   typedef logic [7:0] cprb_data_t;
   typedef logic [12:0] cprb_addr_t;
   typedef enum logic [1:0] {
      CPRB_IDLE = 2'b00,
      CPRB_INSTR = 2'b01,
      CPRB_DATA = 2'b10
   } cprb_state_e;
endpackage

// >>> common/cprb_bus_if.sv
// register access carrier between the serial port and the register bank
// assumes both ends run on one clock
`timescale 1ns/100ps
interface cprb_bus_if;
   import cprb_pkg::*;
   logic wr_en;
   cprb_addr_t wr_addr;
   cprb_data_t wdata;
   cprb_addr_t rd_addr;
   cprb_data_t rdata;
   modport ctrl (output wr_en, output wr_addr, output wdata, output rd_addr, input rdata);
   modport regs (input wr_en, input wr_addr, input wdata, input rd_addr, output rdata);
endinterface

// >>> hdl/cprb_spi_slave.sv
// serial port engine: 16-bit instruction, then streamed data bytes, msb first
// assumes pins already synchronised and sclk at most one eighth of clk
`timescale 1ns/100ps
`include "cprb_defines.svh"
module cprb_spi_slave (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // synchronised pins, and sdo_active from the port config register
   input wire logic sclk_s,
   input wire logic csb_s,
   input wire logic sdio_s,
   input wire logic sdo_active,
   // register access
   cprb_bus_if.ctrl bus,
   // serial outputs
   output logic sdo_out,
   output logic sdo_oe,
   output logic sdio_out,
   output logic sdio_oe
);
   import cprb_pkg::*;

   cprb_state_e state_ff, nxt_state;
   logic sclk_d_ff, nxt_sclk_d;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [15:0] shift_ff, nxt_shift;
   cprb_addr_t addr_ff, nxt_addr;
   logic rd_ff, nxt_rd;
   logic load_ff, nxt_load;
   cprb_data_t out_ff, nxt_out;
   logic bit_ff, nxt_bit;
   logic wr_ff, nxt_wr;
   cprb_addr_t wr_addr_ff, nxt_wr_addr;
   cprb_data_t wdata_ff, nxt_wdata;
   logic nxt_oe;
   logic sdo_oe_ff, nxt_sdo_oe;
   logic sdio_oe_ff, nxt_sdio_oe;
   logic rise, fall;

   assign rise = sclk_s & ~sclk_d_ff;
   assign fall = ~sclk_s & sclk_d_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_sclk_d = sclk_s;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_addr = addr_ff;
      nxt_rd = rd_ff;
      nxt_load = 1'b0;
      nxt_out = out_ff;
      nxt_bit = bit_ff;
      nxt_wr = 1'b0;
      nxt_wr_addr = wr_addr_ff;
      nxt_wdata = wdata_ff;
      if (load_ff) begin
         nxt_out = bus.rdata;
      end
      case (state_ff)
         CPRB_IDLE: begin
            nxt_cnt = 4'h0;
            if (!csb_s) begin
               nxt_state = CPRB_INSTR;
            end
         end
         CPRB_INSTR: begin
            if (rise) begin
               nxt_shift = {shift_ff[14:0], sdio_s};
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == `CPRB_INSTR_LAST) begin
                  nxt_rd = shift_ff[`CPRB_RD_BIT];
                  nxt_addr = {shift_ff[11:0], sdio_s};
                  nxt_load = shift_ff[`CPRB_RD_BIT];
                  nxt_cnt = 4'h0;
                  nxt_state = CPRB_DATA;
               end
            end
         end
         CPRB_DATA: begin
            if (rise) begin
               nxt_shift = {shift_ff[14:0], sdio_s};
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == `CPRB_BYTE_LAST) begin
                  nxt_cnt = 4'h0;
                  nxt_wr = ~rd_ff;
                  nxt_wr_addr = addr_ff;
                  nxt_wdata = {shift_ff[6:0], sdio_s};
                  nxt_addr = addr_ff - 13'h0001;
                  nxt_load = rd_ff;
               end
            end
            if (fall && rd_ff) begin
               nxt_bit = out_ff[7];
               nxt_out = {out_ff[6:0], 1'b0};
            end
         end
         default: begin
            nxt_state = CPRB_IDLE;
         end
      endcase
      if (csb_s) begin
         nxt_state = CPRB_IDLE;
         nxt_load = 1'b0;
      end
      nxt_oe = (nxt_state == CPRB_DATA) && nxt_rd;
      nxt_sdo_oe = nxt_oe && sdo_active;
      nxt_sdio_oe = nxt_oe && !sdo_active;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_ff <= CPRB_IDLE;
         sclk_d_ff <= 1'b0;
         cnt_ff <= 4'h0;
         shift_ff <= 16'h0000;
         addr_ff <= 13'h0000;
         rd_ff <= 1'b0;
         load_ff <= 1'b0;
         out_ff <= 8'h00;
         bit_ff <= 1'b0;
         wr_ff <= 1'b0;
         wr_addr_ff <= 13'h0000;
         wdata_ff <= 8'h00;
         sdo_oe_ff <= 1'b0;
         sdio_oe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sclk_d_ff <= nxt_sclk_d;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         addr_ff <= nxt_addr;
         rd_ff <= nxt_rd;
         load_ff <= nxt_load;
         out_ff <= nxt_out;
         bit_ff <= nxt_bit;
         wr_ff <= nxt_wr;
         wr_addr_ff <= nxt_wr_addr;
         wdata_ff <= nxt_wdata;
         sdo_oe_ff <= nxt_sdo_oe;
         sdio_oe_ff <= nxt_sdio_oe;
      end
   end

   assign bus.wr_en = wr_ff;
   assign bus.wr_addr = wr_addr_ff;
   assign bus.wdata = wdata_ff;
   assign bus.rd_addr = addr_ff;
   assign sdo_out = bit_ff;
   assign sdio_out = bit_ff;
   assign sdo_oe = sdo_oe_ff;
   assign sdio_oe = sdio_oe_ff;
endmodule

// >>> hdl/cprb_regbank.sv
// clock generator pll register bank, addresses 0x000 to 0x016, on a serial port
// assumes pins from outside the clk domain; unlisted addresses read as zero
//
// Summary of operation
// - writes to unmapped addresses change nothing
// - reference divider bits 13..8 from 0x012
// - feedback divider low byte at 0x014
// - feedback bits 12..8 at 0x015, reset zero
`timescale 1ns/100ps
`include "cprb_defines.svh"
module cprb_regbank (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // serial pins
   input wire logic sclk,
   input wire logic csb,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic sdo_out,
   output logic sdo_oe,
   // configuration to the pll
   output cprb_pkg::cprb_data_t pump_cfg,
   output logic [13:0] ref_div,
   output logic [5:0] swallow_cnt,
   output logic [12:0] fb_div,
   output cprb_pkg::cprb_data_t loop_ctrl,
   output logic readback_active,
   output cprb_pkg::cprb_data_t port_cfg
);
   import cprb_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] pin_raw;
   logic sync1_ff [3];
   logic sync2_ff [3];
   logic sdo_active;
   assign pin_raw = {sclk, csb, sdio_in};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               sync1_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
               sync2_ff[gi] <= (gi == 1) ? 1'b1 : 1'b0;
            end else begin
               sync1_ff[gi] <= pin_raw[gi];
               sync2_ff[gi] <= sync1_ff[gi];
            end
         end
      end
   endgenerate

   cprb_bus_if bus ();

   cprb_spi_slave u_spi (
      .clk(clk),
      .rst_b(rst_b),
      .sclk_s(sync2_ff[2]),
      .csb_s(sync2_ff[1]),
      .sdio_s(sync2_ff[0]),
      .sdo_active(sdo_active),
      .bus(bus),
      .sdo_out(sdo_out),
      .sdo_oe(sdo_oe),
      .sdio_out(sdio_out),
      .sdio_oe(sdio_oe)
   );

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   cprb_data_t cfg_ff, nxt_cfg;
   cprb_data_t rb_sel_ff, nxt_rb_sel;
   cprb_data_t ee_lo_ff, nxt_ee_lo;
   cprb_data_t ee_hi_ff, nxt_ee_hi;
   cprb_data_t pump_ff, nxt_pump;
   logic [13:0] ref_ff, nxt_ref;
   logic [5:0] swal_ff, nxt_swal;
   logic [12:0] fb_ff, nxt_fb;
   cprb_data_t loop_ff, nxt_loop;
   logic srst_req;

   assign srst_req = bus.wr_en && (bus.wr_addr == `CPRB_OFS_PORT_CFG) &&
      (bus.wdata[`CPRB_CFG_SRST_HI] || bus.wdata[`CPRB_CFG_SRST_LO]);

   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_rb_sel = rb_sel_ff;
      nxt_ee_lo = ee_lo_ff;
      nxt_ee_hi = ee_hi_ff;
      nxt_pump = pump_ff;
      nxt_ref = ref_ff;
      nxt_swal = swal_ff;
      nxt_fb = fb_ff;
      nxt_loop = loop_ff;
      if (srst_req) begin
         // soft reset restores defaults and its bits never store
         nxt_cfg = `CPRB_RST_PORT_CFG;
         nxt_rb_sel = `CPRB_RST_RB_SEL;
         nxt_ee_lo = `CPRB_RST_EE_VER;
         nxt_ee_hi = `CPRB_RST_EE_VER;
         nxt_pump = `CPRB_RST_PUMP;
         nxt_ref = `CPRB_RST_REF_DIV;
         nxt_swal = `CPRB_RST_SWALLOW;
         nxt_fb = `CPRB_RST_FB_DIV;
         nxt_loop = `CPRB_RST_LOOP1;
      end else if (bus.wr_en) begin
         // addresses without a case item fall through untouched
         case (bus.wr_addr)
            `CPRB_OFS_PORT_CFG: nxt_cfg = bus.wdata & `CPRB_CFG_KEEP_MASK;
            `CPRB_OFS_RB_SEL: nxt_rb_sel = bus.wdata & `CPRB_RB_SEL_MASK;
            `CPRB_OFS_EE_VER_LO: nxt_ee_lo = bus.wdata;
            `CPRB_OFS_EE_VER_HI: nxt_ee_hi = bus.wdata;
            `CPRB_OFS_PUMP: nxt_pump = bus.wdata;
            `CPRB_OFS_REF_LO: nxt_ref[7:0] = bus.wdata;
            `CPRB_OFS_REF_HI: nxt_ref[13:8] = bus.wdata[`CPRB_REF_HI_W-1:0];
            `CPRB_OFS_SWALLOW: nxt_swal = bus.wdata[`CPRB_SWALLOW_W-1:0];
            `CPRB_OFS_FB_LO: nxt_fb[7:0] = bus.wdata;
            `CPRB_OFS_FB_HI: nxt_fb[12:8] = bus.wdata[`CPRB_FB_HI_W-1:0];
            `CPRB_OFS_LOOP1: nxt_loop = bus.wdata;
            default: nxt_cfg = cfg_ff;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cfg_ff <= `CPRB_RST_PORT_CFG;
         rb_sel_ff <= `CPRB_RST_RB_SEL;
         ee_lo_ff <= `CPRB_RST_EE_VER;
         ee_hi_ff <= `CPRB_RST_EE_VER;
         pump_ff <= `CPRB_RST_PUMP;
         ref_ff <= `CPRB_RST_REF_DIV;
         swal_ff <= `CPRB_RST_SWALLOW;
         fb_ff <= `CPRB_RST_FB_DIV;
         loop_ff <= `CPRB_RST_LOOP1;
      end else begin
         cfg_ff <= nxt_cfg;
         rb_sel_ff <= nxt_rb_sel;
         ee_lo_ff <= nxt_ee_lo;
         ee_hi_ff <= nxt_ee_hi;
         pump_ff <= nxt_pump;
         ref_ff <= nxt_ref;
         swal_ff <= nxt_swal;
         fb_ff <= nxt_fb;
         loop_ff <= nxt_loop;
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      case (bus.rd_addr)
         `CPRB_OFS_PORT_CFG: bus.rdata = cfg_ff;
         `CPRB_OFS_SI_REV: bus.rdata = `CPRB_SI_REV_VAL;
         `CPRB_OFS_PART_IDENTIFIER: bus.rdata = `CPRB_PART_IDENTIFIER_VAL;
         `CPRB_OFS_RB_SEL: bus.rdata = rb_sel_ff;
         `CPRB_OFS_EE_VER_LO: bus.rdata = ee_lo_ff;
         `CPRB_OFS_EE_VER_HI: bus.rdata = ee_hi_ff;
         `CPRB_OFS_PUMP: bus.rdata = pump_ff;
         `CPRB_OFS_REF_LO: bus.rdata = ref_ff[7:0];
         `CPRB_OFS_REF_HI: bus.rdata = {2'b00, ref_ff[13:8]};
         `CPRB_OFS_SWALLOW: bus.rdata = {2'b00, swal_ff};
         `CPRB_OFS_FB_LO: bus.rdata = fb_ff[7:0];
         `CPRB_OFS_FB_HI: bus.rdata = {3'b000, fb_ff[12:8]};
         `CPRB_OFS_LOOP1: bus.rdata = loop_ff;
         default: bus.rdata = 8'h00;
      endcase
   end

   assign sdo_active = cfg_ff[`CPRB_CFG_SDO_HI] | cfg_ff[`CPRB_CFG_SDO_LO];
   assign pump_cfg = pump_ff;
   assign ref_div = ref_ff;
   assign swallow_cnt = swal_ff;
   assign fb_div = fb_ff;
   assign loop_ctrl = loop_ff;
   assign readback_active = rb_sel_ff[0];
   assign port_cfg = cfg_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [80:0] all_state;
   logic mapped_wr;
   assign all_state = {cfg_ff, rb_sel_ff, ee_lo_ff, ee_hi_ff, pump_ff, ref_ff, swal_ff,
      fb_ff, loop_ff};
   assign mapped_wr = (bus.wr_addr <= `CPRB_OFS_LOOP1) &&
      ((bus.wr_addr <= `CPRB_OFS_EE_VER_HI) || (bus.wr_addr >= `CPRB_OFS_PUMP)) &&
      (bus.wr_addr != 13'h0001);

   sequence s_srst_write;
      bus.wr_en && (bus.wr_addr == `CPRB_OFS_PORT_CFG) &&
         (bus.wdata[`CPRB_CFG_SRST_HI] || bus.wdata[`CPRB_CFG_SRST_LO]);
   endsequence

   sequence s_write_to(logic [12:0] ofs);
      bus.wr_en && (bus.wr_addr == ofs);
   endsequence

   a_unmapped_write_ignored: assert property (@(posedge clk) disable iff (!rst_b)
      (bus.wr_en && !mapped_wr) |=> (all_state == $past(all_state)))
      else $error("unmapped write changed register state");

   a_ref_low_store: assert property (@(posedge clk) disable iff (!rst_b)
      s_write_to(`CPRB_OFS_REF_LO) |=> (ref_ff[7:0] == $past(bus.wdata)) &&
         (ref_ff[13:8] == $past(ref_ff[13:8])))
      else $error("reference divider low byte not stored");

   a_ref_high_mask: assert property (@(posedge clk) disable iff (!rst_b)
      s_write_to(`CPRB_OFS_REF_HI) |=> (ref_ff[13:8] == $past(bus.wdata[5:0])) &&
         (ref_ff[7:0] == $past(ref_ff[7:0])))
      else $error("reference divider high bits wrong");

   a_fb_low_store: assert property (@(posedge clk) disable iff (!rst_b)
      s_write_to(`CPRB_OFS_FB_LO) |=> (fb_div[7:0] == $past(bus.wdata)) &&
         (fb_div[12:8] == $past(fb_div[12:8])))
      else $error("feedback divider low byte not stored");

   a_fb_high_mask: assert property (@(posedge clk) disable iff (!rst_b)
      s_write_to(`CPRB_OFS_FB_HI) |=> (fb_div[12:8] == $past(bus.wdata[4:0])))
      else $error("feedback divider high bits wrong");

   a_fb_high_reset: assert property (@(posedge clk)
      !rst_b |=> (fb_div[12:8] == 5'h00))
      else $error("feedback divider high bits not zero after reset");

   a_soft_reset_clear: assert property (@(posedge clk) disable iff (!rst_b)
      s_srst_write |=> (cfg_ff == 8'h00) && (ref_ff == `CPRB_RST_REF_DIV) &&
         (pump_ff == `CPRB_RST_PUMP) && (loop_ff == `CPRB_RST_LOOP1))
      else $error("soft reset did not restore defaults");
endmodule

// >>> testbench/cprb_spi_host.sv
// host controller model on the serial port: sends 16-bit instructions and data msb first
// assumes the bench calls access() from one process and clk is the bank's clock
`timescale 1ns/100ps
module cprb_spi_host (
   // clock
   input wire logic clk,
   // serial pins toward the bank
   output logic sclk,
   output logic csb,
   output logic sdio_in,
   // read data from the bank
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic sdo_out,
   input wire logic sdo_oe
);
   logic drv;
   logic drv_en;
   // output enables seen at the first data bit of the last transfer
   logic [1:0] oe_seen;

   // ------------------------------------------------------------
   // data line: bank, host, or inverse of last bit once released
   // ------------------------------------------------------------
   assign sdio_in = sdio_oe ? sdio_out : (drv_en ? drv : ~drv);

   initial begin
      sclk = 1'b0;
      csb = 1'b1;
      drv = 1'b0;
      drv_en = 1'b1;
      oe_seen = 2'b00;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one sclk period of ten clk, data changed while sclk is low
   task automatic shift_bit(input logic b, output logic r);
      drv = b;
      tick(5);
      sclk = 1'b1;
      r = sdo_oe ? sdo_out : sdio_out;
      tick(5);
      sclk = 1'b0;
   endtask

   // ------------------------------------------------------------
   // one transfer: instruction, then nbits of data from wd[15] down
   // ------------------------------------------------------------
   task automatic access(input logic rd, input logic [12:0] a, input int nbits,
                         input logic [15:0] wd, output logic [15:0] rv);
      logic [15:0] instr;
      logic r;
      instr = {rd, 2'b00, a};
      rv = '0;
      csb = 1'b0;
      tick(3);
      for (int i = 15; i >= 0; i--) begin
         shift_bit(instr[i], r);
      end
      drv_en = !rd;
      for (int i = 0; i < nbits; i++) begin
         shift_bit(wd[15 - i], r);
         rv = {rv[14:0], r};
         if (i == 0) begin
            oe_seen = {sdo_oe, sdio_oe};
         end
      end
      tick(3);
      csb = 1'b1;
      drv_en = 1'b1;
      tick(6);
   endtask
endmodule

// >>> testbench/clock_pll_config_register_bank_test.sv
// self-checking bench of the register bank through its serial port
// assumes cprb_spi_host as the host and the bank's defines for expectations
`timescale 1ns/100ps
`include "cprb_defines.svh"
module clock_pll_config_register_bank_test;
   import cprb_pkg::*;
   logic clk;
   logic rst_b;
   logic sclk;
   logic csb;
   logic sdio_in;
   logic sdio_out;
   logic sdio_oe;
   logic sdo_out;
   logic sdo_oe;
   cprb_data_t pump_cfg;
   logic [13:0] ref_div;
   logic [5:0] swallow_cnt;
   logic [12:0] fb_div;
   cprb_data_t loop_ctrl;
   logic readback_active;
   cprb_data_t port_cfg;
   int n_mismatch;
   int n_tests;
   logic [15:0] rv;

   // ------------------------------------------------------------
   // rows: address, byte written, byte read back
   // ------------------------------------------------------------
   localparam logic [28:0] ROWS [16] = '{
      {13'h0000, 8'h81, 8'h81},
      {13'h0004, 8'h01, 8'h01},
      {13'h0005, 8'hA5, 8'hA5},
      {13'h0006, 8'h3C, 8'h3C},
      {13'h0010, 8'h5A, 8'h5A},
      {13'h0011, 8'hFF, 8'hFF},
      {13'h0012, 8'h3F, 8'h3F},
      {13'h0013, 8'h2A, 8'h2A},
      {13'h0014, 8'hC3, 8'hC3},
      {13'h0015, 8'h1F, 8'h1F},
      {13'h0016, 8'h81, 8'h81},
      {13'h0002, 8'h00, `CPRB_SI_REV_VAL},
      {13'h0003, 8'h00, `CPRB_PART_IDENTIFIER_VAL},
      {13'h0007, 8'h00, 8'h00},
      {13'h0017, 8'hFF, 8'h00},
      {13'h1FFF, 8'hFF, 8'h00}
   };
   localparam logic [20:0] RST_ROWS [8] = '{
      {13'h0000, 8'h00}, {13'h0004, 8'h00}, {13'h0005, 8'h00}, {13'h0006, 8'h00},
      {13'h0010, 8'h7D}, {13'h0011, 8'h01}, {13'h0015, 8'h00}, {13'h0016, 8'h06}
   };

   always #25 clk = ~clk;

   cprb_spi_host u_host (
      .clk(clk), .sclk(sclk), .csb(csb), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe)
   );

   cprb_regbank u_dut (
      .clk(clk), .rst_b(rst_b), .sclk(sclk), .csb(csb), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .pump_cfg(pump_cfg), .ref_div(ref_div), .swallow_cnt(swallow_cnt),
      .fb_div(fb_div), .loop_ctrl(loop_ctrl), .readback_active(readback_active),
      .port_cfg(port_cfg)
   );

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // watchdog, about five times the expected run
   // ------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      conclude();
   end

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      // defaults after reset
      chk("ref_div reset", 16'(`CPRB_RST_REF_DIV), 16'(ref_div));
      chk("fb_div reset", 16'(`CPRB_RST_FB_DIV), 16'(fb_div));
      for (int i = 0; i < 8; i++) begin
         u_host.access(1'b1, RST_ROWS[i][20:8], 8, 16'h0000, rv);
         chk("reset readback", {8'h00, RST_ROWS[i][7:0]}, rv);
         chk("reset read oe", 16'h0001, 16'(u_host.oe_seen));
      end
      // ordinary writes and readbacks
      for (int i = 0; i < 16; i++) begin
         u_host.access(1'b0, ROWS[i][28:16], 8, {ROWS[i][15:8], 8'h00}, rv);
         chk("row write oe", 16'h0000, 16'(u_host.oe_seen));
         u_host.access(1'b1, ROWS[i][28:16], 8, 16'h0000, rv);
         chk("row readback", {8'h00, ROWS[i][7:0]}, rv);
         chk("row read oe", 16'h0002, 16'(u_host.oe_seen));
      end
      chk("ref_div", 16'h3FFF, 16'(ref_div));
      chk("fb_div", 16'h1FC3, 16'(fb_div));
      chk("swallow_cnt", 16'h002A, 16'(swallow_cnt));
      chk("pump_cfg", 16'h005A, 16'(pump_cfg));
      chk("loop_ctrl", 16'h0081, 16'(loop_ctrl));
      chk("readback_active", 16'h0001, 16'(readback_active));
      chk("port_cfg", 16'h0081, 16'(port_cfg));
      // streamed read across both feedback bytes, address falling
      u_host.access(1'b1, 13'h0015, 16, 16'h0000, rv);
      chk("stream read fb", 16'h1FC3, rv);
      // stream starting unmapped: first byte dropped, second lands in 0x016
      u_host.access(1'b0, 13'h0017, 16, 16'hFF42, rv);
      chk("loop_ctrl stream", 16'h0042, 16'(loop_ctrl));
      u_host.access(1'b0, 13'h0012, 16, 16'h0123, rv);
      chk("ref_div stream", 16'h0123, 16'(ref_div));
      // aborted byte leaves the register alone
      u_host.access(1'b0, 13'h0010, 4, 16'hF000, rv);
      chk("pump_cfg abort", 16'h005A, 16'(pump_cfg));
      // mid-run reset returns ref_div, fb_div and loop_ctrl to their defaults
      rst_b = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("ref_div mid reset", 16'(`CPRB_RST_REF_DIV), 16'(ref_div));
      chk("fb_div mid reset", 16'(`CPRB_RST_FB_DIV), 16'(fb_div));
      chk("loop_ctrl mid reset", 16'(`CPRB_RST_LOOP1), 16'(loop_ctrl));
      // soft reset through each mirrored bit
      for (int i = 0; i < 2; i++) begin
         u_host.access(1'b0, 13'h0011, 8, 16'h5500, rv);
         u_host.access(1'b0, 13'h0000, 8, {(i == 0) ? 8'h20 : 8'h04, 8'h00}, rv);
         chk("ref_div soft", 16'(`CPRB_RST_REF_DIV), 16'(ref_div));
         chk("pump_cfg soft", 16'(`CPRB_RST_PUMP), 16'(pump_cfg));
         chk("port_cfg soft", 16'h0000, 16'(port_cfg));
         u_host.access(1'b1, 13'h0000, 8, 16'h0000, rv);
         chk("config readback", 16'h0000, rv);
         chk("soft read oe", 16'h0001, 16'(u_host.oe_seen));
         chk("oe idle", 16'h0000, 16'({sdo_oe, sdio_oe}));
      end
      conclude();
   end
endmodule
